/* logic/adc_sample_packet_control.sv */
// Converter control: APB registers, calibration pulse count, sample packing
// and packet framing towards the on-chip channel network.
// Assumes the converter core returns one result per enabled pin per trigger
// and that the network side takes a token whenever tx_ready is high.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps

module adc_sample_packet_control
	import adc_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                trigger,
	input  wire logic                sample_valid,
	input  wire sample_s             sample,
	output logic                     conv_on,
	output logic                     conv_cal_sel,
	output logic      [NUM_PINS-1:0] conv_pin_en,
	output logic                     tx_valid,
	input  wire logic                tx_ready,
	output token_s                   tx_token,
	output logic                     irq
);

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Address falls on one of the eight pin registers
	function automatic logic is_pin_addr(input logic [ADDR_W-1:0] a);
		return (a >= OFF_PIN0) && (a <= OFF_PIN_LAST) && (a[1:0] == 2'h0);
	endfunction

	// Address is any mapped register
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return is_pin_addr(a) || (a == OFF_GEN) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
	endfunction

	// Left-aligned word, first byte in the top lane
	function automatic logic [31:0] pack_word(input logic [CODE_W-1:0] c, input logic [1:0] w);
		logic [31:0] r;
		r = 32'h0;
		unique case (w)
			WID_8:   r = {c[CODE_W-1:4], 24'h000000};
			WID_16:  r = {c, 4'h0, 16'h0000};
			default: r = {c, 20'h00000};
		endcase
		return r;
	endfunction

	// Bytes on the wire for a width code
	function automatic logic [2:0] width_bytes(input logic [1:0] w);
		logic [2:0] r;
		r = BYTES_32;
		unique case (w)
			WID_8:   r = BYTES_8;
			WID_16:  r = BYTES_16;
			default: r = BYTES_32;
		endcase
		return r;
	endfunction

	// Lowest open pin, used when closing packets
	function automatic logic [PIN_W-1:0] first_pin(input logic [NUM_PINS-1:0] m);
		logic [PIN_W-1:0] r;
		r = '0;
		for (int i = NUM_PINS - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = PIN_W'(i);
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [DEST_W-1:0]   dest_reg [NUM_PINS];  // Destination per pin
	logic [NUM_PINS-1:0] pin_en_reg;           // Pin sampling enables
	logic                on_reg;               // Global enable
	logic                cal_reg;              // Reference input select
	logic [SPP_W-1:0]    spp_reg;              // Samples per packet
	logic [WID_W-1:0]    wid_reg;              // Sample width code
	logic                lost_reg;             // Sample dropped flag
	logic [IRQ_W-1:0]    irq_stat_reg;         // Sticky event bits
	logic [IRQ_W-1:0]    irq_mask_reg;         // Event enables
	logic [31:0]         prdata_reg;           // Read data, set in setup
	logic                pslverr_reg;          // Unmapped access flag
	logic [2:0]          cal_cnt_reg;          // Calibration pulses seen
	logic                deliver_reg;          // Results may be sent
	logic                hold_valid_reg;       // Result waiting to send
	sample_s             hold_reg;             // That result
	tx_state_e           state_reg;            // Sender state
	logic [PIN_W-1:0]    cur_pin_reg;          // Pin being sent
	logic [31:0]         word_reg;             // Bytes still to send
	logic [2:0]          left_reg;             // Byte count remaining
	logic [DEST_W-1:0]   tx_dest_reg;          // Destination on the wire
	logic [SPP_W-1:0]    cnt_reg [NUM_PINS];   // Samples in open packet
	logic [NUM_PINS-1:0] open_reg;             // Packet open per pin
	logic                close_req_reg;        // Close all open packets

	////////////////////////////////////////////////////////////////////////
	// Bus phase decode

	logic                setup;       // Setup cycle
	logic                access;      // Access cycle, transfer completes
	logic                wr_acc;      // Completing write
	logic                rd_acc;      // Completing read
	logic [PIN_W-1:0]    pin_idx;     // Pin register addressed
	logic                pin_wr;      // Accepted pin register write
	logic                gen_wr;      // General control write
	logic                take;        // Sender takes the held result
	logic                accept;      // Result is for delivery
	logic                drop;        // Result lost
	logic                data_done;   // Last byte of a sample taken
	logic                term_done;   // End token taken
	logic [SPP_W-1:0]    cnt_inc;     // Count after this sample
	logic                pkt_full;    // Packet reached its length

	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign wr_acc  = access && pwrite;
	assign rd_acc  = access && !pwrite;
	assign pin_idx = paddr[PIN_W+1:2];
	assign pin_wr  = wr_acc && is_pin_addr(paddr) && !on_reg;
	assign gen_wr  = wr_acc && (paddr == OFF_GEN);

	// Zero wait state: read data is staged in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////
	// Per-pin control registers

	// eight pin registers at word spacing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				dest_reg[i] <= '0;
			end
			pin_en_reg <= '0;
		end else if (pin_wr) begin
			dest_reg[pin_idx] <= pwdata[PIN_DEST_LSB +: DEST_W];
			pin_en_reg[pin_idx] <= pwdata[PIN_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// General control register

	// A reserved width code would leave the sender without a format, so it is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_reg  <= 1'b0;
			cal_reg <= 1'b0;
			spp_reg <= SPP_RST;
			wid_reg <= WID_RST;
		end else if (gen_wr) begin
			on_reg  <= pwdata[GEN_ON_BIT];
			cal_reg <= pwdata[GEN_CAL_BIT];
			spp_reg <= pwdata[SPP_LSB +: SPP_W];
			if (pwdata[WID_LSB +: WID_W] != WID_RSV) begin
				wid_reg <= pwdata[WID_LSB +: WID_W];
			end
		end
	end

	// set wins; only a bit that was read is cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lost_reg <= LOST_RST;
		end else if (drop) begin
			lost_reg <= 1'b1;
		end else if (rd_acc && (paddr == OFF_GEN) && prdata_reg[LOST_BIT]) begin
			lost_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask

	// Write one to clear; a new event in the same cycle stays set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_acc && (paddr == OFF_IRQ_STAT)) ? pwdata[IRQ_W-1:0] : '0))
			              | {(cal_cnt_reg == CAL_PULSES - 3'h1) && on_reg && trigger, term_done, drop};
			if (wr_acc && (paddr == OFF_IRQ_MASK)) begin
				irq_mask_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////
	// Read data and error staging

	// Read data is captured in setup so it comes straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= !is_mapped(paddr);
			prdata_reg  <= '0;
			if (is_pin_addr(paddr)) begin
				prdata_reg[PIN_DEST_LSB +: DEST_W] <= dest_reg[pin_idx];
				prdata_reg[PIN_EN_BIT]             <= pin_en_reg[pin_idx];
			end else if (paddr == OFF_GEN) begin
				prdata_reg[GEN_ON_BIT]           <= on_reg;
				prdata_reg[GEN_CAL_BIT]          <= cal_reg;
				prdata_reg[SPP_LSB +: SPP_W]     <= spp_reg;
				prdata_reg[WID_LSB +: WID_W]     <= wid_reg;
				prdata_reg[LOST_BIT]             <= lost_reg;
			end else if (paddr == OFF_IRQ_STAT) begin
				prdata_reg[IRQ_W-1:0] <= irq_stat_reg;
			end else if (paddr == OFF_IRQ_MASK) begin
				prdata_reg[IRQ_W-1:0] <= irq_mask_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calibration pulse counting

	// count restarts whenever the converter is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_cnt_reg <= '0;
			deliver_reg <= 1'b0;
		end else if (!on_reg) begin
			cal_cnt_reg <= '0;
			deliver_reg <= 1'b0;
		end else if (trigger) begin
			if (cal_cnt_reg != CAL_PULSES) begin
				cal_cnt_reg <= cal_cnt_reg + 3'h1;
			end else begin
				deliver_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result holding register

	assign accept = sample_valid && deliver_reg && pin_en_reg[sample.pin];
	assign take   = (state_reg == ST_IDLE) && hold_valid_reg && !(close_req_reg && (open_reg != '0));
	// result lost over an unsent one
	assign drop   = accept && hold_valid_reg && !take;

	// One result deep: the converter cannot be stalled, so overrun is flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_valid_reg <= 1'b0;
			hold_reg       <= '0;
		end else if (accept && !drop) begin
			hold_valid_reg <= 1'b1;
			hold_reg       <= sample;
		end else if (take) begin
			hold_valid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Packet framing per pin

	assign data_done = (state_reg == ST_DATA) && tx_ready && (left_reg == 3'h1);
	assign term_done = (state_reg == ST_TERM) && tx_ready;
	assign cnt_inc   = cnt_reg[cur_pin_reg] + SPP_W'(1);
	// packet ends after the set count
	assign pkt_full  = (spp_reg != '0) && (cnt_inc == spp_reg);

	// Counts and open flags follow the sender
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				cnt_reg[i] <= '0;
			end
			open_reg <= '0;
		end else if (term_done) begin
			cnt_reg[cur_pin_reg]  <= '0;
			open_reg[cur_pin_reg] <= 1'b0;
		end else if (data_done) begin
			cnt_reg[cur_pin_reg]  <= cnt_inc;
			open_reg[cur_pin_reg] <= 1'b1;
		end
	end

	// any access to a mapped register ends open packets when length is zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			close_req_reg <= 1'b0;
		end else if (access && is_mapped(paddr) && (spp_reg == '0)) begin
			close_req_reg <= 1'b1;
		end else if ((state_reg == ST_IDLE) && (open_reg == '0)) begin
			close_req_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sender state machine

	// Closing takes priority so a stale packet ends before new data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			cur_pin_reg <= '0;
			word_reg    <= '0;
			left_reg    <= '0;
			tx_dest_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (close_req_reg && (open_reg != '0)) begin
						cur_pin_reg <= first_pin(open_reg);
						tx_dest_reg <= dest_reg[first_pin(open_reg)];
						word_reg    <= '0;
						state_reg   <= ST_TERM;
					end else if (take) begin
						cur_pin_reg <= hold_reg.pin;
						tx_dest_reg <= dest_reg[hold_reg.pin];
						word_reg    <= pack_word(hold_reg.code, wid_reg);
						left_reg    <= width_bytes(wid_reg);
						state_reg   <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_ready) begin
						word_reg <= {word_reg[23:0], 8'h00};
						left_reg <= left_reg - 3'h1;
						if (left_reg == 3'h1) begin
							state_reg <= pkt_full ? ST_TERM : ST_IDLE;
						end
					end
				end
				ST_TERM: begin
					if (tx_ready) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign tx_valid      = (state_reg != ST_IDLE);
	assign tx_token.dest = tx_dest_reg;
	assign tx_token.data = word_reg[31:24];
	assign tx_token.last = (state_reg == ST_TERM);
	assign conv_on       = on_reg;
	assign conv_cal_sel  = cal_reg;
	assign conv_pin_en   = pin_en_reg;

endmodule

/* logic/adc_pkg.sv */
// Shared constants and types for the converter sample packet control.
// Assumes a 32-bit APB register bus and a byte-wide channel network port.
package adc_pkg;

	// Geometry
	localparam int NUM_PINS  = 8;
	localparam int PIN_W     = 3;
	localparam int CODE_W    = 12;
	localparam int DEST_W    = 24;
	localparam int ADDR_W    = 8;
	localparam int IRQ_W     = 3;

	// Register byte offsets
	localparam logic [7:0] OFF_PIN0     = 8'h00;
	localparam logic [7:0] OFF_PIN_LAST = 8'h1C;
	localparam logic [7:0] OFF_GEN      = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

	// Per-pin register fields
	localparam int PIN_EN_BIT   = 0;
	localparam int PIN_DEST_LSB = 8;

	// General control fields
	localparam int GEN_ON_BIT   = 0;
	localparam int GEN_CAL_BIT  = 1;
	localparam int SPP_LSB      = 8;
	localparam int SPP_W        = 8;
	localparam int WID_LSB      = 16;
	localparam int WID_W        = 2;
	localparam int LOST_BIT     = 24;

	// Reset values
	localparam logic [7:0] SPP_RST  = 8'h01;
	localparam logic [1:0] WID_RST  = 2'h1;
	localparam logic       LOST_RST = 1'b1;

	// Sample width codes
	localparam logic [1:0] WID_8   = 2'h0;
	localparam logic [1:0] WID_16  = 2'h1;
	localparam logic [1:0] WID_RSV = 2'h2;
	localparam logic [1:0] WID_32  = 2'h3;

	// Bytes sent per sample
	localparam logic [2:0] BYTES_8  = 3'h1;
	localparam logic [2:0] BYTES_16 = 3'h2;
	localparam logic [2:0] BYTES_32 = 3'h4;

	// Trigger pulses spent on calibration after enabling
	localparam logic [2:0] CAL_PULSES = 3'h6;

	// Interrupt status bit positions
	localparam int IRQ_DROP = 0;
	localparam int IRQ_PKT  = 1;
	localparam int IRQ_CAL  = 2;

	// Sender states, Gray coded along idle, data, terminate
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01,
		ST_TERM = 2'b11
	} tx_state_e;

	// Conversion result from the converter core
	typedef struct packed {
		logic [PIN_W-1:0]  pin;
		logic [CODE_W-1:0] code;
	} sample_s;

	// Token towards the channel network
	typedef struct packed {
		logic [DEST_W-1:0] dest;
		logic [7:0]        data;
		logic              last;
	} token_s;

endpackage

/* sim/adc_packet_monitor.sv */
// Concurrent checks on the converter packet control ports.
// Assumes one pclk domain; bound into every instance of the block.
`timescale 1ns/100ps
module adc_packet_monitor
	import adc_pkg::*;
(
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic		pslverr,
	input wire logic		trigger,
	input wire logic		sample_valid,
	input wire sample_s		sample,
	input wire logic		conv_on,
	input wire logic		conv_cal_sel,
	input wire logic [7:0]	conv_pin_en,
	input wire logic		tx_valid,
	input wire logic		tx_ready,
	input wire token_s		tx_token
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	logic [2:0]	cal_cnt;	// Pulses since enable, stops at 7
	logic		wr_go;		// APB write takes effect
	logic		pin_wr;		// That write hits a pin register
	assign wr_go = psel && penable && pwrite;
	assign pin_wr = wr_go && paddr <= OFF_PIN_LAST;
	// Triggers count only while on, so a disable restarts calibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cal_cnt <= 3'h0;
		else if (!conv_on)
			cal_cnt <= 3'h0;
		else if (trigger && cal_cnt != 3'h7)
			cal_cnt <= cal_cnt + 3'h1;
	end
	////////////////////////////////////////////////////////////////////////
	property p_on;
		wr_go && paddr == OFF_GEN |=> conv_on == $past(pwdata[0]);
	endproperty
	a_on: assert property (p_on) else $error("enable level differs from write");
	property p_cal_sel;
		wr_go && paddr == OFF_GEN |=> conv_cal_sel == $past(pwdata[1]);
	endproperty
	a_cal_sel: assert property (p_cal_sel) else $error("reference select differs from write");
	property p_pin_ro;
		pin_wr && conv_on |=> $stable(conv_pin_en);
	endproperty
	a_pin_ro: assert property (p_pin_ro) else $error("pin enable changed while on");
	property p_pin_en;
		pin_wr && !conv_on |=> conv_pin_en[$past(paddr[4:2])] == $past(pwdata[0]);
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin enable not written");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_token);
	endproperty
	a_hold: assert property (p_hold) else $error("token changed before taken");
	property p_end_zero;
		tx_valid && tx_token.last |-> tx_token.data == 8'h00;
	endproperty
	a_end_zero: assert property (p_end_zero) else $error("end token carries data");
	property p_unmapped;
		psel && !penable && paddr > OFF_IRQ_MASK |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_cal_quiet;
		sample_valid && conv_on && cal_cnt < 3'h7 && !tx_valid && !psel && !$past(sample_valid)
			|=> !tx_valid [*3];
	endproperty
	a_cal_quiet: assert property (p_cal_quiet) else $error("packet sent during calibration");
	property p_deliver;
		sample_valid && conv_on && cal_cnt == 3'h7 && conv_pin_en[sample.pin] && !tx_valid && !psel
			&& !$past(tx_valid) && !$past(psel) && !$past(sample_valid)
			|-> ##2 tx_valid && !tx_token.last && tx_token.data == $past(sample.code[11:4], 2);
	endproperty
	a_deliver: assert property (p_deliver) else $error("first sample byte wrong or late");
	// Main scenarios reached
	c_stall: cover property (tx_valid && !tx_ready);
	c_end: cover property (tx_valid && tx_ready && tx_token.last);
	c_deliver: cover property (sample_valid && cal_cnt == 3'h7);
endmodule
bind adc_sample_packet_control adc_packet_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.trigger(trigger), .sample_valid(sample_valid), .sample(sample), .conv_on(conv_on),
	.conv_cal_sel(conv_cal_sel), .conv_pin_en(conv_pin_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_token(tx_token));

/* sim/chan_end_model.sv */
// Receiving channel-end: takes network tokens and queues them in order.
// Assumes the bench steers stall and slow to shape back-pressure.
`timescale 1ns/100ps
module chan_end_model
	import adc_pkg::*;
(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	stall,
	input wire logic	slow,
	input wire logic	tx_valid,
	input wire token_s	tx_token,
	output logic		tx_ready
);
	token_s	q[$];	// Tokens taken, oldest first
	logic	phase;	// Half-rate acceptance in slow mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end
	// Stall starves the sender so the single hold register can overrun
	assign tx_ready = presetn && !stall && (!slow || phase);
	always @(posedge pclk) begin
		if (presetn && tx_valid && tx_ready)
			q.push_back(tx_token);
	end
endmodule

/* sim/tb.sv */
// Self-checking bench: APB master, converter result driver, channel-end.
// Assumes the block answers APB with pready and a one-cycle access phase.
`timescale 1ns/100ps
module tb
	import adc_pkg::*;
;
	logic			pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic			trigger, sample_valid, conv_on, conv_cal_sel, tx_valid, tx_ready, stall, slow;
	logic [7:0]		paddr, conv_pin_en;
	logic [31:0]	pwdata, prdata;
	logic [32:0]	rword;	// Error flag over read data
	sample_s		sample;
	token_s			tx_token;
	int				n_errors, check_count, cycles;
	adc_sample_packet_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger(trigger), .sample_valid(sample_valid), .sample(sample),
		.conv_on(conv_on), .conv_cal_sel(conv_cal_sel), .conv_pin_en(conv_pin_en), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_token(tx_token), .irq(irq));
	chan_end_model far_end (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
		.tx_valid(tx_valid), .tx_token(tx_token), .tx_ready(tx_ready));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; an idle edge after it lets register outputs land
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rword = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic fire(input logic [2:0] p, input logic [11:0] c);
		@(posedge pclk);
		trigger <= 1'b1;
		@(posedge pclk);
		trigger <= 1'b0;
		sample_valid <= 1'b1;
		sample <= '{pin: p, code: c};
		@(posedge pclk);
		sample_valid <= 1'b0;
	endtask
	task automatic tok(input logic [23:0] d, input logic [7:0] v, input logic l);
		token_s t;
		int i;
		t = 'x;
		for (i = 0; i < 200 && far_end.q.size() == 0; i++)
			@(posedge pclk);
		if (far_end.q.size() != 0)
			t = far_end.q.pop_front();
		chk(t, {d, v, l});
	endtask
	task automatic flush(input int n);
		repeat (60) @(posedge pclk);
		chk(33'(far_end.q.size()), 33'(n));
		far_end.q.delete();
	endtask
	function automatic logic [23:0] dst(input int i);
		return 24'hC0DE00 + 24'(i);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		for (int i = 0; i < NUM_PINS; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rword, 33'h0);
		end
		apb(1'b0, OFF_GEN, 32'h0);
		chk(rword, 33'h0_0101_0100);
		apb(1'b0, OFF_GEN, 32'h0);
		chk(rword, 33'h0_0001_0100);
		apb(1'b1, 8'h2C, 32'hFFFF_FFFF);
		chk(rword, 33'h1_0000_0000);
	endtask
	task automatic t_pins();
		logic en;
		for (int i = 0; i < NUM_PINS; i++) begin
			en = (i == 3 || i == 5);
			apb(1'b1, 8'(4 * i), {dst(i), 7'h7F, en});
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rword, {1'b0, dst(i), 7'h00, en});
		end
		chk(33'(conv_pin_en), 33'h28);
	endtask
	task automatic t_cal();
		apb(1'b1, OFF_GEN, 32'h0000_0101);
		chk(33'(conv_on), 33'h1);
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rword, {1'b0, dst(3), 8'h01});
		repeat (6) fire(3'h3, 12'h5A5);
		flush(0);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk(rword, 33'h4);
		chk(33'(irq), 33'h0);
		apb(1'b1, OFF_IRQ_MASK, 32'h4);
		@(posedge pclk);
		chk(33'(irq), 33'h1);
		apb(1'b1, OFF_IRQ_STAT, 32'h4);
		@(posedge pclk);
		chk(33'(irq), 33'h0);
		fire(3'h3, 12'h5A5);
		tok(dst(3), 8'h5A, 1'b0);
		tok(dst(3), 8'h00, 1'b1);
		fire(3'h2, 12'hFFF);
		flush(0);
	endtask
	task automatic t_formats();
		logic [1:0] w[3] = '{WID_8, WID_16, WID_32};
		logic [2:0] n[3] = '{BYTES_8, BYTES_16, BYTES_32};
		logic [31:0] word = {12'h9C7, 20'h0};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFF_GEN, {14'h0, w[i], 8'h01, 8'h01});
			fire(3'h5, 12'h9C7);
			for (int b = 0; b < n[i]; b++)
				tok(dst(5), word[31 - 8 * b -: 8], 1'b0);
			tok(dst(5), 8'h00, 1'b1);
		end
		apb(1'b1, OFF_GEN, {14'h0, WID_RSV, 8'h01, 8'h03});
		apb(1'b0, OFF_GEN, 32'h0);
		chk(33'(rword[17:16]), 33'(WID_32));
		chk(33'(conv_cal_sel), 33'h1);
		fire(3'h5, 12'h111);
		flush(5);
		apb(1'b1, OFF_GEN, 32'h0000_0101);
	endtask
	task automatic t_spp();
		apb(1'b1, OFF_GEN, 32'h0000_0201);
		fire(3'h3, 12'hA10);
		fire(3'h3, 12'hB20);
		tok(dst(3), 8'hA1, 1'b0);
		tok(dst(3), 8'hB2, 1'b0);
		tok(dst(3), 8'h00, 1'b1);
		apb(1'b1, OFF_GEN, 32'h0000_0001);
		fire(3'h5, 12'hC30);
		fire(3'h3, 12'hD40);
		tok(dst(5), 8'hC3, 1'b0);
		tok(dst(3), 8'hD4, 1'b0);
		flush(0);
		apb(1'b0, OFF_GEN, 32'h0);
		tok(dst(3), 8'h00, 1'b1);
		tok(dst(5), 8'h00, 1'b1);
		apb(1'b1, OFF_GEN, 32'h0000_0101);
	endtask
	// A stalled network lets the third result land on a full hold register
	task automatic t_overrun();
		stall <= 1'b1;
		repeat (3) fire(3'h3, 12'h420);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk(33'(rword[2:0]), 33'h3);
		apb(1'b0, OFF_GEN, 32'h0);
		chk(33'(rword[24]), 33'h1);
		apb(1'b0, OFF_GEN, 32'h0);
		chk(33'(rword[24]), 33'h0);
		slow <= 1'b1;
		stall <= 1'b0;
		flush(4);
		slow <= 1'b0;
	endtask
	task automatic t_reenable();
		apb(1'b1, OFF_GEN, 32'h0000_0100);
		chk(33'(conv_on), 33'h0);
		apb(1'b1, OFF_GEN, 32'h0000_0101);
		repeat (6) fire(3'h3, 12'h777);
		flush(0);
		fire(3'h3, 12'h888);
		tok(dst(3), 8'h88, 1'b0);
		tok(dst(3), 8'h00, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, trigger, sample_valid, stall, slow} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		sample = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pins();
		t_cal();
		t_formats();
		t_spp();
		t_overrun();
		t_reenable();
		wrap_up();
	end
endmodule
